//--- rtl/ssc_consts.vh
// Constants for the switch system control register bank.
// Assumes inclusion by ssc_regs.v only; definitions only.
`ifndef SSC_CONSTS_VH
`define SSC_CONSTS_VH
// ----------------------------------------
// Register offsets and reset values
// ----------------------------------------
`define SSC_OFS_CTRL_TWO    8'h10
`define SSC_OFS_CTRL_THREE  8'h11
`define SSC_OFS_CTRL_FOUR   8'h12
`define SSC_RST_CTRL_TWO    16'h0040
`define SSC_RST_CTRL_THREE  16'hE000
`define SSC_RST_CTRL_FOUR   16'h3600
// ----------------------------------------
// Field positions
// ----------------------------------------
`define SSC_B_RX_CLK_FB     6
`define SSC_B_GROUP_CNT     5
`define SSC_B_CRC_OFF       4
`define SSC_B_RETRY_OFF     3
`define SSC_B_FLOOD_GUARD   2
`define SSC_F_CAP_LEVEL     1:0
`define SSC_F_HOST_INDEX    15:13
`define SSC_B_TAG_RX        12
`define SSC_B_TAG_TX        11
`define SSC_B_TAG_PAUSE     10
`define SSC_F_SIZE_LIMIT    9:7
`define SSC_B_SCHEME_NEW    6
`define SSC_B_VLAN_TAG      5
`define SSC_B_CLONE         4
`define SSC_B_QUEUE_TEST    3
`define SSC_B_IRQ_INV       2
`define SSC_F_AGE_SEL       1:0
`define SSC_B_DROP_COLL     15
`define SSC_B_TEN_LIMIT     11
`define SSC_B_PAUSE_IGN     5
`define SSC_NO_HOST         3'h7
// ----------------------------------------
// Frame lengths, aging periods, thresholds
// ----------------------------------------
`define SSC_LEN_1518        11'h5EE
`define SSC_LEN_1536        11'h600
`define SSC_LEN_1664        11'h680
`define SSC_LEN_1522        11'h5F2
`define SSC_LEN_1784        11'h6F8
`define SSC_AGE_300S        9'h12C
`define SSC_AGE_75S         9'h04B
`define SSC_AGE_18S         9'h012
`define SSC_AGE_1S          9'h001
`define SSC_CAP_LVL0        16'h0010
`define SSC_CAP_LVL1        16'h0040
`define SSC_CAP_LVL2        16'h0100
`define SSC_CAP_LVL3        16'h0400
`define SSC_CAP_NEW         16'h0080
// ----------------------------------------
// Timing
// ----------------------------------------
`define SSC_CLK_PERIOD_NS   8
`define SSC_RX_STOP_NS      800
`define SSC_STORM_WIN_NS    5000000
`endif

//--- rtl/ssc_regs.v
// Global control register bank of a six-port 10/100 switch.
// Assumes a plain register port on sys_clk_i and a same-clock
// switch core; the serial receive clock arrives as a pin.
`timescale 1ns/10ps
`include "ssc_consts.vh"

module ssc_regs #(
    parameter STORM_WIN_CYC = `SSC_STORM_WIN_NS / `SSC_CLK_PERIOD_NS
) (
    input  wire        sys_clk_i,
    input  wire        rst_i,
    input  wire [7:0]  reg_addr_i,
    input  wire [15:0] reg_wdata_i,
    input  wire        reg_wr_i,
    input  wire        reg_rd_i,
    output wire [15:0] reg_rdata_o,
    input  wire        serial_rx_clk_i,
    output wire        rx_clk_use_tx_o,
    input  wire        frame_done_i,
    input  wire        frame_bcast_i,
    input  wire        frame_mcast_i,
    output wire [15:0] storm_count_o,
    output wire        storm_drop_o,
    output wire        crc_check_on_o,
    output wire        backoff_on_o,
    output wire [2:0]  host_link_index_o,
    output wire        host_present_o,
    output wire        host_tag_rx_on_o,
    input  wire [2:0]  tx_port_i,
    input  wire        tx_is_pause_i,
    output wire        tag_insert_o,
    output wire [10:0] max_frame_len_o,
    output wire        vlan_by_tag_o,
    output wire        hw_addr_clone_on_o,
    input  wire        irq_event_i,
    output wire        irq_pin_o,
    output wire [8:0]  age_period_sec_o,
    output wire        drop_on_excess_coll_o,
    output wire        ten_limit_on_o,
    input  wire        full_duplex_i,
    input  wire        flow_ctrl_on_i,
    output wire        pause_ignore_o
);

// ----------------------------------------
// Timing counts
// ----------------------------------------
// Longest quiet time rounds down to whole cycles
localparam integer RX_STOP_CYC = `SSC_RX_STOP_NS / `SSC_CLK_PERIOD_NS;
localparam [7:0]   RX_STOP_MAX = RX_STOP_CYC[7:0];
localparam integer STORM_LAST_I = STORM_WIN_CYC - 1;
localparam [22:0]  STORM_LAST  = STORM_LAST_I[22:0];

// ----------------------------------------
// Register storage
// ----------------------------------------
reg  [15:0] ctrl_two_ff;
reg  [15:0] ctrl_three_ff;
reg  [15:0] ctrl_four_ff;
reg  [15:0] rdata_ff;
reg  [15:0] nxt_rdata;

wire        wr_two   = reg_wr_i && (reg_addr_i == `SSC_OFS_CTRL_TWO);
wire        wr_three = reg_wr_i && (reg_addr_i == `SSC_OFS_CTRL_THREE);
wire        wr_four  = reg_wr_i && (reg_addr_i == `SSC_OFS_CTRL_FOUR);

always @(posedge sys_clk_i) begin
    if (rst_i) begin
        ctrl_two_ff   <= `SSC_RST_CTRL_TWO;
        ctrl_three_ff <= `SSC_RST_CTRL_THREE;
        ctrl_four_ff  <= `SSC_RST_CTRL_FOUR;
    end else begin
        if (wr_two) begin
            ctrl_two_ff <= reg_wdata_i;
        end
        if (wr_three) begin
            ctrl_three_ff <= reg_wdata_i;
        end
        if (wr_four) begin
            ctrl_four_ff <= reg_wdata_i;
        end
    end
end

// ----------------------------------------
// Read port
// ----------------------------------------
// Unmapped addresses read zero; data stands one cycle only
always @* begin
    nxt_rdata = 16'h0000;
    if (!reg_rd_i) begin
        nxt_rdata = 16'h0000;
    end else if (reg_addr_i == `SSC_OFS_CTRL_TWO) begin
        nxt_rdata = ctrl_two_ff;
    end else if (reg_addr_i == `SSC_OFS_CTRL_THREE) begin
        nxt_rdata = ctrl_three_ff;
    end else if (reg_addr_i == `SSC_OFS_CTRL_FOUR) begin
        nxt_rdata = ctrl_four_ff;
    end
end

always @(posedge sys_clk_i) begin
    if (rst_i) begin
        rdata_ff <= 16'h0000;
    end else begin
        rdata_ff <= nxt_rdata;
    end
end

assign reg_rdata_o = rdata_ff;

// ----------------------------------------
// Field aliases
// ----------------------------------------
wire       rx_clk_fallback    = ctrl_two_ff[`SSC_B_RX_CLK_FB];
wire       count_group_frames = ctrl_two_ff[`SSC_B_GROUP_CNT];
wire       crc_verify_off     = ctrl_two_ff[`SSC_B_CRC_OFF];
wire       retry_delay_off    = ctrl_two_ff[`SSC_B_RETRY_OFF];
wire       flood_guard_on     = ctrl_two_ff[`SSC_B_FLOOD_GUARD];
wire [1:0] flood_cap_level    = ctrl_two_ff[`SSC_F_CAP_LEVEL];
wire [2:0] host_link_index    = ctrl_three_ff[`SSC_F_HOST_INDEX];
wire       host_tag_rx_on     = ctrl_three_ff[`SSC_B_TAG_RX];
wire       host_tag_tx_on     = ctrl_three_ff[`SSC_B_TAG_TX];
wire       pause_tag_on       = ctrl_three_ff[`SSC_B_TAG_PAUSE];
wire [2:0] frame_size_limit   = ctrl_three_ff[`SSC_F_SIZE_LIMIT];
wire       flood_scheme_new   = ctrl_three_ff[`SSC_B_SCHEME_NEW];
wire       irq_level_invert   = ctrl_three_ff[`SSC_B_IRQ_INV];
wire [1:0] age_period_sel     = ctrl_three_ff[`SSC_F_AGE_SEL];
wire       flow_frame_ignore  = ctrl_four_ff[`SSC_B_PAUSE_IGN];

// ----------------------------------------
// Receive clock watchdog
// ----------------------------------------
// Pin is asynchronous: two stages before the edge detector
reg        rxc_meta_ff;
reg        rxc_sync_ff;
reg        rxc_last_ff;
reg  [7:0] rxc_quiet_ff;
reg  [7:0] nxt_rxc_quiet;
reg        rxc_stopped_ff;
reg        nxt_rxc_stopped;

wire       rxc_edge = rxc_sync_ff ^ rxc_last_ff;

always @* begin
    nxt_rxc_quiet   = rxc_quiet_ff;
    nxt_rxc_stopped = rxc_stopped_ff;
    if (rxc_edge) begin
        nxt_rxc_quiet   = 8'h00;
        nxt_rxc_stopped = 1'b0;
    end else if (rxc_quiet_ff >= RX_STOP_MAX - 8'h01) begin
        nxt_rxc_stopped = 1'b1;
    end else begin
        nxt_rxc_quiet = rxc_quiet_ff + 8'h01;
    end
end

always @(posedge sys_clk_i) begin
    if (rst_i) begin
        rxc_meta_ff    <= 1'b0;
        rxc_sync_ff    <= 1'b0;
        rxc_last_ff    <= 1'b0;
        rxc_quiet_ff   <= 8'h00;
        rxc_stopped_ff <= 1'b0;
    end else begin
        rxc_meta_ff    <= serial_rx_clk_i;
        rxc_sync_ff    <= rxc_meta_ff;
        rxc_last_ff    <= rxc_sync_ff;
        rxc_quiet_ff   <= nxt_rxc_quiet;
        rxc_stopped_ff <= nxt_rxc_stopped;
    end
end

// Glitch-free mux is the clock tree's job; this is its select
assign rx_clk_use_tx_o = rx_clk_fallback && rxc_stopped_ff;

// ----------------------------------------
// Storm control
// ----------------------------------------
reg  [15:0] storm_cnt_ff;
reg  [15:0] nxt_storm_cnt;
reg  [22:0] storm_win_ff;
reg  [22:0] nxt_storm_win;
reg  [15:0] storm_cap;

wire        win_end = (storm_win_ff == STORM_LAST);
wire        storm_frame = frame_bcast_i ||
                          (count_group_frames && frame_mcast_i);
wire        storm_guard = flood_scheme_new || flood_guard_on;

always @* begin
    if (flood_scheme_new) begin
        storm_cap = `SSC_CAP_NEW;
    end else begin
        case (flood_cap_level)
            2'h0:    storm_cap = `SSC_CAP_LVL0;
            2'h1:    storm_cap = `SSC_CAP_LVL1;
            2'h2:    storm_cap = `SSC_CAP_LVL2;
            default: storm_cap = `SSC_CAP_LVL3;
        endcase
    end
end

always @* begin
    nxt_storm_win = storm_win_ff + 23'h000001;
    nxt_storm_cnt = storm_cnt_ff;
    if (win_end) begin
        nxt_storm_win = 23'h000000;
        nxt_storm_cnt = 16'h0000;
    end else if (frame_done_i && storm_frame &&
                 storm_cnt_ff != 16'hFFFF) begin
        nxt_storm_cnt = storm_cnt_ff + 16'h0001;
    end
end

always @(posedge sys_clk_i) begin
    if (rst_i) begin
        storm_cnt_ff <= 16'h0000;
        storm_win_ff <= 23'h000000;
    end else begin
        storm_cnt_ff <= nxt_storm_cnt;
        storm_win_ff <= nxt_storm_win;
    end
end

assign storm_count_o = storm_cnt_ff;
// Counted frames over the cap are dropped for the rest of the window
assign storm_drop_o  = storm_guard && storm_frame &&
                       (storm_cnt_ff >= storm_cap);

// ----------------------------------------
// Frame handling controls
// ----------------------------------------
assign crc_check_on_o    = !crc_verify_off;
assign backoff_on_o      = !retry_delay_off;

wire   host_present      = (host_link_index != `SSC_NO_HOST);
assign host_link_index_o = host_link_index;
assign host_present_o    = host_present;
assign host_tag_rx_on_o  = host_tag_rx_on;

// Tag only toward a real CPU port; pause frames need their own enable
assign tag_insert_o = host_tag_tx_on && host_present &&
                      (tx_port_i == host_link_index) &&
                      (!tx_is_pause_i || pause_tag_on);

reg [10:0] max_len;
always @* begin
    case (frame_size_limit)
        3'h0:    max_len = `SSC_LEN_1518;
        3'h1:    max_len = `SSC_LEN_1536;
        3'h2:    max_len = `SSC_LEN_1664;
        3'h6:    max_len = `SSC_LEN_1522;
        default: max_len = `SSC_LEN_1784;
    endcase
end
assign max_frame_len_o = max_len;

assign vlan_by_tag_o      = ctrl_three_ff[`SSC_B_VLAN_TAG];
assign hw_addr_clone_on_o = ctrl_three_ff[`SSC_B_CLONE];

// ----------------------------------------
// Interrupt pin polarity
// ----------------------------------------
// Idle level follows the polarity so the pin never pulses on change
reg irq_pin_ff;
always @(posedge sys_clk_i) begin
    if (rst_i) begin
        irq_pin_ff <= 1'b1;
    end else begin
        irq_pin_ff <= irq_level_invert ? irq_event_i : !irq_event_i;
    end
end
assign irq_pin_o = irq_pin_ff;

// ----------------------------------------
// Address aging period
// ----------------------------------------
reg [8:0] age_sec;
always @* begin
    case (age_period_sel)
        2'h0:    age_sec = `SSC_AGE_300S;
        2'h1:    age_sec = `SSC_AGE_75S;
        2'h2:    age_sec = `SSC_AGE_18S;
        default: age_sec = `SSC_AGE_1S;
    endcase
end
assign age_period_sec_o = age_sec;

// ----------------------------------------
// Fourth control register effects
// ----------------------------------------
assign drop_on_excess_coll_o = ctrl_four_ff[`SSC_B_DROP_COLL];
assign ten_limit_on_o        = ctrl_four_ff[`SSC_B_TEN_LIMIT];
// Full duplex with flow control still honours pause
assign pause_ignore_o = flow_frame_ignore &&
                        (!full_duplex_i || !flow_ctrl_on_i);

endmodule

//--- bench/ssc_regs_asserts.sv
// Checker for the system control register bank.
// Bound to ssc_regs; sees its ports only.
`timescale 1ns/10ps
module ssc_regs_asserts (
    input logic        sys_clk_i,
    input logic        rst_i,
    input logic [7:0]  reg_addr_i,
    input logic [15:0] reg_wdata_i,
    input logic        reg_wr_i,
    input logic        reg_rd_i,
    input logic [15:0] reg_rdata_o,
    input logic        crc_check_on_o,
    input logic        backoff_on_o,
    input logic [2:0]  host_link_index_o,
    input logic        host_present_o,
    input logic [2:0]  tx_port_i,
    input logic        tag_insert_o,
    input logic        irq_event_i,
    input logic        irq_pin_o,
    input logic        full_duplex_i,
    input logic        flow_ctrl_on_i,
    input logic        pause_ignore_o,
    input logic        drop_on_excess_coll_o,
    input logic        ten_limit_on_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    sequence wr4; reg_wr_i && reg_addr_i == 8'h12; endsequence
    sequence rd4; reg_rd_i && reg_addr_i == 8'h12; endsequence
    sequence wr3; reg_wr_i && reg_addr_i == 8'h11; endsequence
    a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 16'h0)
        else $error("read data not zero when idle");
    a_unmapped_zero: assert property (
        reg_rd_i && (reg_addr_i < 8'h10 || reg_addr_i > 8'h12) |=> reg_rdata_o == 16'h0)
        else $error("unmapped read not zero");
    a_four_readback: assert property (
        wr4 ##1 rd4 |=> reg_rdata_o == $past(reg_wdata_i, 2))
        else $error("control four readback wrong");
    a_four_fields: assert property (wr4 |=>
        drop_on_excess_coll_o == $past(reg_wdata_i[15]) && ten_limit_on_o == $past(reg_wdata_i[11]))
        else $error("control four outputs wrong");
    a_two_fields: assert property (reg_wr_i && reg_addr_i == 8'h10 |=>
        crc_check_on_o == !$past(reg_wdata_i[4]) && backoff_on_o == !$past(reg_wdata_i[3]))
        else $error("crc or backoff enable wrong");
    a_host_none: assert property (host_present_o == (host_link_index_o != 3'h7))
        else $error("host presence wrong");
    a_host_index: assert property (wr3 |=> host_link_index_o == $past(reg_wdata_i[15:13]))
        else $error("host index wrong");
    a_tag_target: assert property (
        tag_insert_o |-> host_present_o && tx_port_i == host_link_index_o)
        else $error("tag on non host port");
    a_irq_follow: assert property (
        $changed(irq_event_i) && !$past(reg_wr_i) && !$past(rst_i) |=> $changed(irq_pin_o))
        else $error("interrupt pin did not follow");
    a_pause_gate: assert property (
        pause_ignore_o |-> !(full_duplex_i && flow_ctrl_on_i))
        else $error("pause ignored with flow control");
endmodule
bind ssc_regs ssc_regs_asserts ssc_regs_asserts_inst (.*);

//--- bench/ssc_tb.sv
// Self-checking bench for the system control register bank.
// Drives every port itself; short storm window for speed.
`timescale 1ns/10ps
module testbench;
    logic sys_clk_i, rst_i, reg_wr_i, reg_rd_i, serial_rx_clk_i, frame_done_i;
    logic frame_bcast_i, frame_mcast_i, tx_is_pause_i, irq_event_i, full_duplex_i;
    logic flow_ctrl_on_i, rx_clk_use_tx_o, storm_drop_o, crc_check_on_o, backoff_on_o;
    logic host_present_o, host_tag_rx_on_o, tag_insert_o, vlan_by_tag_o, irq_pin_o;
    logic hw_addr_clone_on_o, drop_on_excess_coll_o, ten_limit_on_o, pause_ignore_o;
    logic [7:0]  reg_addr_i;
    logic [15:0] reg_wdata_i, reg_rdata_o, storm_count_o;
    logic [2:0]  host_link_index_o, tx_port_i;
    logic [10:0] max_frame_len_o;
    logic [8:0]  age_period_sec_o;
    logic        rx_run;
    int          error_cnt, tests_run, i;
    ssc_regs #(.STORM_WIN_CYC(64)) ssc_regs_inst (.*);
    initial begin
        sys_clk_i = 1'b0;
        forever #4 sys_clk_i = ~sys_clk_i;
    end
    // Odd period keeps all but every 40th pin edge (each 532 ns) off the core clock edges
    initial forever #13.3 if (rx_run) serial_rx_clk_i = ~serial_rx_clk_i;
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(string n, logic [15:0] s, logic [15:0] e);
        tests_run++;
        if (s !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [15:0] d);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
        #1;
    endtask
    task automatic rd(logic [7:0] a, logic [15:0] e);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b0;
        #1 chk("rdata", reg_rdata_o, e);
    endtask
    // Write then read with no gap between the strobes
    task automatic wr_rd(logic [7:0] a, logic [15:0] d);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
        reg_rd_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b0;
        #1 chk("rdata", reg_rdata_o, d);
    endtask
    task automatic fr(int n, logic b, logic m);
        @(posedge sys_clk_i);
        frame_done_i <= 1'b1;
        frame_bcast_i <= b;
        frame_mcast_i <= m;
        repeat (n) @(posedge sys_clk_i);
        frame_done_i <= 1'b0;
        #1;
    endtask
    function automatic logic [15:0] len_of(int m);
        case (m)
            0: return 16'h05EE;
            1: return 16'h0600;
            2: return 16'h0680;
            6: return 16'h05F2;
            default: return 16'h06F8;
        endcase
    endfunction
    task end_of_test;
        if (error_cnt == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        #20000;
        error_cnt++;
        end_of_test;
    end
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        {reg_wr_i, reg_rd_i, frame_done_i, frame_bcast_i, frame_mcast_i} = 5'h0;
        {tx_is_pause_i, irq_event_i, full_duplex_i, flow_ctrl_on_i} = 4'h0;
        {reg_addr_i, reg_wdata_i, tx_port_i, serial_rx_clk_i} = 28'h0;
        rst_i = 1'b1;
        rx_run = 1'b1;
        repeat (2) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        rd(8'h10, 16'h0040);
        rd(8'h11, 16'hE000);
        rd(8'h12, 16'h3600);
        chk("present", host_present_o, 0);
        chk("len", max_frame_len_o, 16'h05EE);
        chk("age", age_period_sec_o, 16'h012C);
        chk("irq", irq_pin_o, 1);
        wr(8'h13, 16'hFFFF);
        rd(8'h13, 16'h0000);
        rd(8'h12, 16'h3600);
        chk("rxfb", rx_clk_use_tx_o, 0);
        wr(8'h10, 16'h0018);
        chk("crc", crc_check_on_o, 0);
        chk("backoff", backoff_on_o, 0);
        rx_run = 1'b0;
        repeat (120) @(posedge sys_clk_i);
        #1 chk("rxfb", rx_clk_use_tx_o, 0);
        wr(8'h10, 16'h0040);
        chk("rxfb", rx_clk_use_tx_o, 1);
        rx_run = 1'b1;
        repeat (10) @(posedge sys_clk_i);
        #1 chk("rxfb", rx_clk_use_tx_o, 0);
        for (i = 0; i < 8; i++) begin
            wr(8'h11, {i[2:0], 2'h3, 1'b0, i[2:0], 1'b0, i[0], i[1], 2'h0, i[1:0]});
            @(posedge sys_clk_i);
            tx_port_i <= i[2:0];
            tx_is_pause_i <= 1'b0;
            #1 chk("index", host_link_index_o, i[2:0]);
            chk("present", host_present_o, i != 7);
            chk("vlan", vlan_by_tag_o, i[0]);
            chk("clone", hw_addr_clone_on_o, i[1]);
            chk("rxtag", host_tag_rx_on_o, 1);
            chk("tag", tag_insert_o, i != 7);
            chk("len", max_frame_len_o, len_of(i));
            chk("age", age_period_sec_o, i[1] ? (i[0] ? 1 : 18) : (i[0] ? 75 : 300));
            @(posedge sys_clk_i);
            tx_is_pause_i <= 1'b1;
            #1 chk("tag", tag_insert_o, 0);
        end
        wr(8'h11, 16'h0C00);
        @(posedge sys_clk_i);
        tx_port_i <= 3'h0;
        #1 chk("tag", tag_insert_o, 1);
        chk("rxtag", host_tag_rx_on_o, 0);
        @(posedge sys_clk_i);
        tx_port_i <= 3'h1;
        #1 chk("tag", tag_insert_o, 0);
        @(posedge sys_clk_i);
        irq_event_i <= 1'b1;
        @(posedge sys_clk_i);
        #1 chk("irq", irq_pin_o, 0);
        wr(8'h11, 16'h0C0C);
        // Pin is registered: new polarity shows one cycle after the write
        @(posedge sys_clk_i);
        #1 chk("irq", irq_pin_o, 1);
        rd(8'h11, 16'h0C0C);
        @(posedge sys_clk_i);
        irq_event_i <= 1'b0;
        @(posedge sys_clk_i);
        #1 chk("irq", irq_pin_o, 0);
        wr_rd(8'h12, 16'h8820);
        chk("drop", drop_on_excess_coll_o, 1);
        chk("ten", ten_limit_on_o, 1);
        for (i = 0; i < 4; i++) begin
            @(posedge sys_clk_i);
            full_duplex_i <= i[0];
            flow_ctrl_on_i <= i[1];
            #1 chk("pauseign", pause_ignore_o, i != 3);
        end
        rd(8'h12, 16'h8820);
        // Fresh reset so the storm window starts at a known cycle
        @(posedge sys_clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        wr(8'h10, 16'h0004);
        fr(3, 1'b0, 1'b1);
        chk("storm", storm_count_o, 0);
        wr(8'h10, 16'h0024);
        fr(2, 1'b0, 1'b1);
        chk("storm", storm_count_o, 2);
        fr(14, 1'b1, 1'b0);
        chk("storm", storm_count_o, 16);
        @(posedge sys_clk_i);
        frame_done_i <= 1'b1;
        #1 chk("sdrop", storm_drop_o, 1);
        // Count is near 18 here: level one raises the cap to 64
        wr(8'h10, 16'h0005);
        chk("sdrop", storm_drop_o, 0);
        wr(8'h10, 16'h0000);
        chk("sdrop", storm_drop_o, 0);
        // Newer scheme lives in the third register, cap 128
        wr(8'h11, 16'h0040);
        chk("sdrop", storm_drop_o, 0);
        @(posedge sys_clk_i);
        frame_done_i <= 1'b0;
        repeat (40) @(posedge sys_clk_i);
        #1 chk("storm", storm_count_o, 0);
        end_of_test;
    end
endmodule
